// ==== shared/ldc_params.svh ====
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH
`define LDC_OFF_WORD_A 8'h00
`define LDC_OFF_WORD_B 8'h04
`define LDC_OFF_WORD_C 8'h08
`define LDC_OFF_ADDR 8'h0C
`define LDC_OFF_CTRL 8'h10
`define LDC_OFF_MANUAL_DATA_A 8'h14
`define LDC_OFF_MANUAL_DATA_B 8'h18
`define LDC_OFF_MANUAL_DATA_C 8'h1C
`define LDC_OFF_MANUAL_ADDR 8'h20
`define LDC_OFF_AUX_DATA_A 8'h24
`define LDC_OFF_AUX_DATA_B 8'h28
`define LDC_OFF_AUX_DATA_C 8'h2C
`define LDC_OFF_AUX_ADDR 8'h30
`define LDC_OFF_STATUS 8'h34
`define LDC_OFF_SPEED 8'h38
`define LDC_OFF_STROBE 8'h3C
`define LDC_CTRL_SEL_LSB 0
`define LDC_CTRL_RUN_BIT 2
`define LDC_CTRL_CLEAR_LSB 4
`define LDC_SPEED_RESET 16'h00FF
`define LDC_SCAN_LAST_LINE 6'h2F
`define LDC_JUMPER_BLOCK 8'h00
`define LDC_RESP_OKAY 2'b00
`define LDC_RESP_SLVERR 2'b10
`endif

// ==== shared/ldc_pkg.sv ====
package ldc_pkg;
    typedef enum logic [1:0] {
        LDC_SRC_HOST,
        LDC_SRC_MANUAL,
        LDC_SRC_SCANNER,
        LDC_SRC_AUX
    } ldc_src_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [47:0] data;
        logic strobe;
        logic spare;
    } ldc_bus_t;
    typedef struct packed {
        logic [31:0] addr;
        logic valid;
    } ldc_ax_t;
endpackage

// ==== src/ldc_top.sv ====
// Summary of operation
// R1 - host sees four sixteen-bit lamp registers
// R2 - three words carry forty-eight light bits
// R3 - bit one lights the lamp, zero darkens it
// R4 - fourth word selects the group of forty-eight lights
// R5 - group decoding uses only the low twelve address bits
// R6 - host writes the four words in a fixed order
// R7 - last word written strobes data and address to latches
// R8 - lamp test forces its sixteen outputs on, over everything
// R9 - twelve cards of forty-eight latches, strobe chosen by slot
// R10 - decoder answers one of 256 jumper-selected blocks of sixteen
// R11 - sixteen card strobes decoded, only first twelve used
// R12 - a card's three clears act as one clear
// R13 - cage driven by 66-line bus: 64 lines, strobe, spare
// R14 - selector enables exactly one of four bus sources
// R15 - scanner gives 4-bit address, one data line, strobe
// R16 - scanner walks the 48 lines from address zero, strobing each
// R17 - after 48 lines scanner address increments by one
// R18 - scanner address low four bits, panel word upper eight
// R19 - scanner covers addresses zero to fifteen
// R20 - stopping the scanner resets its counter to zero
// R21 - scanner step rate set by a speed value
// R22 - latches hold until next addressed strobe or clear
`include "ldc_params.svh"
module ldc_top
    import ldc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [35:0] lamp_test,
    input wire logic [11:0] card_clear,
    output logic [575:0] lamp_out
);
    logic [47:0] host_data_reg;
    logic [15:0] host_addr_reg;
    logic host_strobe_reg;
    logic [47:0] manual_data_reg;
    logic [15:0] manual_addr_reg;
    logic manual_strobe_reg;
    logic [47:0] aux_data_reg;
    logic [15:0] aux_addr_reg;
    logic aux_strobe_reg;
    logic [1:0] sel_reg;
    logic run_reg;
    logic [11:0] sw_clear_reg;
    logic [15:0] speed_reg;
    logic [15:0] rate_cnt_reg;
    logic step_reg;
    logic [5:0] line_reg;
    logic [3:0] scan_addr_reg;
    logic scan_strobe_reg;
    ldc_bus_t bus_reg;
    logic [47:0] latch_reg [0:11];
    ldc_ax_t aw_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wd_valid_reg;
    logic [1:0] bresp_reg;
    logic bvalid_reg;
    logic arready_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rvalid_reg;
    logic [575:0] lamp_reg;
    logic do_write;
    logic [7:0] woff;
    logic [15:0] wval;
    logic wmapped;
    logic [31:0] rd_next;
    logic rmapped;
    ldc_bus_t bus_next;
    logic [47:0] scan_line;

    assign do_write = aw_reg.valid && wd_valid_reg && !bvalid_reg;
    assign woff = aw_reg.addr[7:0];
    assign wval = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
                   wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};

    // axi write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg <= '0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            wd_valid_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_reg.valid) begin
                aw_reg <= '{addr: s_axi_awaddr, valid: 1'b1};
            end else if (do_write) begin
                aw_reg.valid <= 1'b0;
            end
            if (s_axi_wvalid && !wd_valid_reg) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                wd_valid_reg <= 1'b1;
            end else if (do_write) begin
                wd_valid_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        wmapped = 1'b1;
        unique case (woff)
            `LDC_OFF_WORD_A, `LDC_OFF_WORD_B, `LDC_OFF_WORD_C, `LDC_OFF_ADDR,
            `LDC_OFF_CTRL, `LDC_OFF_MANUAL_DATA_A, `LDC_OFF_MANUAL_DATA_B,
            `LDC_OFF_MANUAL_DATA_C, `LDC_OFF_MANUAL_ADDR, `LDC_OFF_AUX_DATA_A,
            `LDC_OFF_AUX_DATA_B, `LDC_OFF_AUX_DATA_C, `LDC_OFF_AUX_ADDR,
            `LDC_OFF_SPEED, `LDC_OFF_STROBE: wmapped = 1'b1;
            default: wmapped = 1'b0;
        endcase
        if (aw_reg.addr[31:8] != 24'h000000) begin
            wmapped = 1'b0;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `LDC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wmapped ? `LDC_RESP_OKAY : `LDC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // R1 R2 R4 host lamp words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_data_reg <= 48'h000000000000;
            host_addr_reg <= 16'h0000;
            host_strobe_reg <= 1'b0;
        end else begin
            host_strobe_reg <= 1'b0;
            if (do_write && aw_reg.addr[31:8] == 24'h000000) begin
                unique case (woff)
                    `LDC_OFF_WORD_A: host_data_reg[15:0] <= wval;
                    `LDC_OFF_WORD_B: host_data_reg[31:16] <= wval;
                    `LDC_OFF_WORD_C: host_data_reg[47:32] <= wval;
                    // R7 address word last, strobes
                    `LDC_OFF_ADDR: begin
                        host_addr_reg <= wval;
                        host_strobe_reg <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // manual panel and auxiliary source words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            manual_data_reg <= 48'h000000000000;
            manual_addr_reg <= 16'h0000;
            manual_strobe_reg <= 1'b0;
            aux_data_reg <= 48'h000000000000;
            aux_addr_reg <= 16'h0000;
            aux_strobe_reg <= 1'b0;
        end else begin
            manual_strobe_reg <= 1'b0;
            aux_strobe_reg <= 1'b0;
            if (do_write && aw_reg.addr[31:8] == 24'h000000) begin
                unique case (woff)
                    `LDC_OFF_MANUAL_DATA_A: manual_data_reg[15:0] <= wval;
                    `LDC_OFF_MANUAL_DATA_B: manual_data_reg[31:16] <= wval;
                    `LDC_OFF_MANUAL_DATA_C: manual_data_reg[47:32] <= wval;
                    `LDC_OFF_MANUAL_ADDR: manual_addr_reg <= wval;
                    `LDC_OFF_AUX_DATA_A: aux_data_reg[15:0] <= wval;
                    `LDC_OFF_AUX_DATA_B: aux_data_reg[31:16] <= wval;
                    `LDC_OFF_AUX_DATA_C: aux_data_reg[47:32] <= wval;
                    `LDC_OFF_AUX_ADDR: aux_addr_reg <= wval;
                    `LDC_OFF_STROBE: begin
                        manual_strobe_reg <= wval[0];
                        aux_strobe_reg <= wval[1];
                    end
                    default: ;
                endcase
            end
        end
    end

    // control, clears and speed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg <= 2'h0;
            run_reg <= 1'b0;
            sw_clear_reg <= 12'h000;
            speed_reg <= `LDC_SPEED_RESET;
        end else if (do_write && aw_reg.addr[31:8] == 24'h000000) begin
            // R14 source select written here
            if (woff == `LDC_OFF_CTRL) begin
                sel_reg <= wdata_reg[`LDC_CTRL_SEL_LSB +: 2];
                run_reg <= wdata_reg[`LDC_CTRL_RUN_BIT];
                sw_clear_reg <= wdata_reg[`LDC_CTRL_CLEAR_LSB +: 12];
            end
            if (woff == `LDC_OFF_SPEED) begin
                speed_reg <= wval;
            end
        end
    end

    // R21 scan rate divider
    always_ff @(posedge aclk) begin
        if (!aresetn || !run_reg) begin
            rate_cnt_reg <= 16'h0000;
            step_reg <= 1'b0;
        end else if (rate_cnt_reg >= speed_reg) begin
            rate_cnt_reg <= 16'h0000;
            step_reg <= 1'b1;
        end else begin
            rate_cnt_reg <= rate_cnt_reg + 16'h0001;
            step_reg <= 1'b0;
        end
    end

    // R16 R17 R19 R20 scanner walk
    always_ff @(posedge aclk) begin
        // R20 stop zeroes the walk
        if (!aresetn || !run_reg) begin
            line_reg <= 6'h00;
            scan_addr_reg <= 4'h0;
            scan_strobe_reg <= 1'b0;
        end else begin
            // R15 R16 strobe after each step
            scan_strobe_reg <= step_reg;
            if (scan_strobe_reg) begin
                // R17 R19 next group after last line
                if (line_reg == `LDC_SCAN_LAST_LINE) begin
                    line_reg <= 6'h00;
                    scan_addr_reg <= scan_addr_reg + 4'h1;
                end else begin
                    line_reg <= line_reg + 6'h01;
                end
            end
        end
    end

    // R15 one-hot scan line
    assign scan_line = 48'h000000000001 << line_reg;

    // R13 R14 R18 source select
    always_comb begin
        bus_next = '0;
        unique case (ldc_src_t'(sel_reg))
            LDC_SRC_HOST:
                bus_next = '{host_addr_reg, host_data_reg, host_strobe_reg, 1'b0};
            LDC_SRC_MANUAL:
                bus_next = '{manual_addr_reg, manual_data_reg, manual_strobe_reg, 1'b0};
            // R18 low four bits from scanner
            LDC_SRC_SCANNER: bus_next = '{{4'h0, manual_addr_reg[11:4], scan_addr_reg},
                                          scan_line, scan_strobe_reg, 1'b0};
            LDC_SRC_AUX: bus_next = '{aux_addr_reg, aux_data_reg, aux_strobe_reg, 1'b0};
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_reg <= '0;
        end else begin
            bus_reg <= bus_next;
        end
    end

    // R5 R9 R10 R11 R12 R22 card latches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int c = 0; c < 12; c++) begin
                latch_reg[c] <= 48'h000000000000;
            end
        end else begin
            // R11 strobes 12 to 15 drive nothing
            for (int c = 0; c < 12; c++) begin
                // R12 R22 clear beats strobe
                if (card_clear[c] || sw_clear_reg[c]) begin
                    latch_reg[c] <= 48'h000000000000;
                end else if (bus_reg.strobe && bus_reg.addr[11:4] == `LDC_JUMPER_BLOCK
                             && bus_reg.addr[3:0] == 4'(c)) begin
                    latch_reg[c] <= bus_reg.data;
                end
            end
        end
    end

    // R3 R8 drivers with lamp test
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamp_reg <= '0;
        end else begin
            for (int c = 0; c < 12; c++) begin
                for (int g = 0; g < 3; g++) begin
                    lamp_reg[c*48 + g*16 +: 16] <= lamp_test[c*3 + g] ? 16'hFFFF
                                                   : latch_reg[c][g*16 +: 16];
                end
            end
        end
    end

    // read side
    always_comb begin
        rd_next = 32'h00000000;
        rmapped = (s_axi_araddr[31:8] == 24'h000000);
        unique case (s_axi_araddr[7:0])
            `LDC_OFF_CTRL: rd_next = {16'h0000, sw_clear_reg, 1'b0, run_reg, sel_reg};
            `LDC_OFF_SPEED: rd_next = {16'h0000, speed_reg};
            `LDC_OFF_STATUS: rd_next = {22'h000000, scan_addr_reg, line_reg};
            `LDC_OFF_WORD_A, `LDC_OFF_WORD_B, `LDC_OFF_WORD_C, `LDC_OFF_ADDR,
            `LDC_OFF_MANUAL_DATA_A, `LDC_OFF_MANUAL_DATA_B, `LDC_OFF_MANUAL_DATA_C,
            `LDC_OFF_MANUAL_ADDR, `LDC_OFF_AUX_DATA_A, `LDC_OFF_AUX_DATA_B,
            `LDC_OFF_AUX_DATA_C, `LDC_OFF_AUX_ADDR, `LDC_OFF_STROBE: rd_next = 32'h00000000;
            default: rmapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `LDC_RESP_OKAY;
        end else begin
            arready_reg <= 1'b0;
            if (rvalid_reg) begin
                if (s_axi_rready) begin
                    rvalid_reg <= 1'b0;
                end
            end else if (s_axi_arvalid && !arready_reg) begin
                arready_reg <= 1'b1;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_next;
                rresp_reg <= rmapped ? `LDC_RESP_OKAY : `LDC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= s_axi_awvalid && !aw_reg.valid && !s_axi_awready;
            s_axi_wready <= s_axi_wvalid && !wd_valid_reg && !s_axi_wready;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign lamp_out = lamp_reg;
endmodule

// ==== sim/ldc_properties.sv ====
`include "ldc_params.svh"
module ldc_properties
    import ldc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [35:0] lamp_test,
    input wire logic [11:0] card_clear,
    input wire logic [575:0] lamp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic aw_bad_reg, rst_reg;
    logic [35:0] test_reg;
    logic [11:0] clear_reg;
    logic [11:0] clear2_reg;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        rst_reg <= aresetn;
        test_reg <= lamp_test;
        clear_reg <= card_clear;
        clear2_reg <= clear_reg;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_bad_reg <= 1'b0;
        end else if (s_axi_awvalid) begin
            aw_bad_reg <= (s_axi_awaddr[31:8] != 24'h000000) || (s_axi_awaddr[7:0] > 8'h3C)
                || (s_axi_awaddr[1:0] != 2'h0) || (s_axi_awaddr[7:0] == `LDC_OFF_STATUS);
        end
    end
    sequence s_read_answer;
        s_axi_arready && s_axi_rvalid;
    endsequence
    a_aw_ready_next: assert property ($rose(s_axi_awvalid) |=> s_axi_awready)
        else $error("awready late");
    a_w_ready_next: assert property ($rose(s_axi_wvalid) |=> s_axi_wready)
        else $error("wready late");
    a_read_answer: assert property ($rose(s_axi_arvalid) |=> s_read_answer)
        else $error("read answer late");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
    a_bresp_code: assert property (s_axi_bvalid
        |-> s_axi_bresp == (aw_bad_reg ? `LDC_RESP_SLVERR : `LDC_RESP_OKAY))
        else $error("bad write response");
    for (genvar k = 0; k < 36; k++) begin : g_test
        a_test_forces: assert property (lamp_test[k] && test_reg[k] && rst_reg
            |-> lamp_out[k*16 +: 16] == 16'hFFFF)
            else $error("lamp test ignored");
    end
    for (genvar c = 0; c < 12; c++) begin : g_clear
        a_clear_wins: assert property (clear_reg[c] && clear2_reg[c] && rst_reg
            && lamp_test[c*3 +: 3] == 3'h0 && test_reg[c*3 +: 3] == 3'h0
            |-> lamp_out[c*48 +: 48] == 48'h000000000000)
            else $error("clear ignored");
    end
endmodule

// ==== sim/ldc_host_model.sv ====
module ldc_host_model (
    input wire logic aclk,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] resp;
    logic [31:0] rdat;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic a_ok, w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        resp = 2'h3;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_bready && s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            a_ok = a_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= a_ok && w_ok;
        end
    endtask
    task automatic rd(input logic [31:0] a);
        resp = 2'h3;
        rdat = 32'hFFFFFFFF;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_rready && s_axi_rvalid) begin
                {rdat, resp} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
                break;
            end
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= s_axi_rready | s_axi_arready;
        end
    endtask
    task automatic update(input logic [15:0] g, input logic [47:0] d);
        wr(32'h00000000, {16'h0000, d[15:0]});
        wr(32'h00000004, {16'h0000, d[31:16]});
        wr(32'h00000008, {16'h0000, d[47:32]});
        wr(32'h0000000C, {16'h0000, g});
    endtask
endmodule

// ==== sim/tb.sv ====
`include "ldc_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] g; logic [47:0] d;} ldc_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [35:0] lamp_test;
    logic [11:0] card_clear;
    logic [575:0] lamp_out, exp_out;
    int error_cnt, tests_run;
    ldc_row_t rows [6] = '{{16'h0000, 48'h0123456789AB}, {16'hF00B, 48'hFFFF0000FFFF},
        {16'h000C, 48'hFFFFFFFFFFFF}, {16'h0013, 48'hFFFFFFFFFFFF},
        {16'h0005, 48'h800000000001}, {16'h0005, 48'h7FFFFFFFFFFE}};
    ldc_top i_ldc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .lamp_test, .card_clear, .lamp_out);
    ldc_host_model i_ldc_host_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic check(input string n, input logic [575:0] s, input logic [575:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
    initial begin
        {aresetn, lamp_test, card_clear, exp_out, error_cnt, tests_run} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        check("reset lamps", lamp_out, exp_out);
        foreach (rows[i]) begin
            i_ldc_host_model.update(rows[i].g, rows[i].d);
            settle();
            if (rows[i].g[11:4] == `LDC_JUMPER_BLOCK && rows[i].g[3:0] < 4'hC) begin
                exp_out[rows[i].g[3:0]*48 +: 48] = rows[i].d;
            end
            check("row lamps", lamp_out, exp_out);
        end
        $display("test rows done");
        i_ldc_host_model.wr(32'h00000100, 32'h00000000);
        check("unmapped write", i_ldc_host_model.resp, `LDC_RESP_SLVERR);
        i_ldc_host_model.rd(32'h00000004);
        check("wo read", {i_ldc_host_model.rdat, i_ldc_host_model.resp}, 34'h000000000);
        $display("test registers done");
        lamp_test[4] <= 1'b1;
        settle();
        check("lamp test", lamp_out, exp_out | {16'hFFFF, 64'h0});
        lamp_test[4] <= 1'b0;
        card_clear[0] <= 1'b1;
        settle();
        exp_out[47:0] = 48'h000000000000;
        i_ldc_host_model.update(16'h0000, 48'hFFFFFFFFFFFF);
        settle();
        card_clear[0] <= 1'b0;
        settle();
        check("clear wins", lamp_out, exp_out);
        $display("test override done");
        for (int s = 1; s < 4; s += 2) begin
            for (int w = 0; w < 3; w++) begin
                i_ldc_host_model.wr(32'h0000000C + 32'(s * 8 + w * 4), 32'(16'h5A00 | 16'(s)));
            end
            i_ldc_host_model.wr(32'h00000018 + 32'(s * 8), 32'(2 + s));
            i_ldc_host_model.wr(32'h00000010, 32'(s));
            i_ldc_host_model.wr(32'h0000003C, 32'((s + 1) / 2));
            settle();
            exp_out[(2 + s)*48 +: 48] = {3{16'h5A00 | 16'(s)}};
            i_ldc_host_model.update(16'h0009, 48'hFFFFFFFFFFFF);
            settle();
            check("source select", lamp_out, exp_out);
        end
        $display("test sources done");
        i_ldc_host_model.wr(32'h00000038, 32'h00000001);
        i_ldc_host_model.wr(32'h00000010, 32'h00000006);
        repeat (1350) @(posedge aclk);
        i_ldc_host_model.wr(32'h00000010, 32'h00000002);
        settle();
        check("scan sweep", lamp_out, {12{48'h800000000000}});
        i_ldc_host_model.rd(32'h00000034);
        check("scan stop", i_ldc_host_model.rdat, 32'h00000000);
        $display("test scanner done");
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        exp_out = '0;
        check("reset lamps again", lamp_out, exp_out);
        i_ldc_host_model.rd(32'h00000038);
        check("reset speed", i_ldc_host_model.rdat, {16'h0000, `LDC_SPEED_RESET});
        $display("test reset done");
        complete_run();
    end
endmodule
bind ldc_top ldc_properties i_ldc_properties (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lamp_test, .card_clear, .lamp_out);
